// File: rtl/jtag_scan_data_registers.sv
// Function
// - msb of each data register takes tdi, lsb feeds tdo
// - identification register is a fixed 20-bit value
// - user identification register is 33 bits, 20 bits user signature
// - unprogrammed user identification bits read as zero
// - each io has enable, output and input cells with shift and hold
// - cells ordered enable, output, input; all ios chained
// - boundary chain length is io count times three
// - bypass is a single bit between tdi and tdo
// - reserved or unused instructions select bypass
// - tap activity visible on four probe outputs
// - tdo driven only in shift states, lsb first, on falling tck
// - 16-state tap controller follows tms on rising tck
// - five-bit instruction register resets to identification instruction
// - instruction capture 11101, errors zero upper three bits until update
`include "scan_regs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module jtag_scan_data_registers #(
  parameter int           NUM_IO    = 4,
  parameter logic [19:0]  ID_VALUE  = 20'h0_1234, // arbitrary value
  parameter logic [32:0]  USER_FUSE = 33'h0_0000_0000
) (
  // system
  input  wire logic              CLK_I,
  input  wire logic              RESETN_I,
  // test port
  input  wire logic              TCK_I,
  input  wire logic              TMS_I,
  input  wire logic              TDI_I,
  input  wire logic              TRSTN_I,
  output logic                   TDO_O,
  output logic                   TDO_OEN_O,
  // error inputs, active low, system clock domain
  input  wire logic [2:0]        ERRN_I,
  // core pins
  input  wire logic [NUM_IO-1:0] PIN_IN_I,
  input  wire logic [NUM_IO-1:0] CORE_OUT_I,
  input  wire logic [NUM_IO-1:0] CORE_OE_I,
  output logic [NUM_IO-1:0]      PIN_OUT_O,
  output logic [NUM_IO-1:0]      PIN_OE_O,
  output logic [NUM_IO-1:0]      CORE_IN_O,
  // probes, system clock domain
  output logic                   PROBE_OUT_A_O,
  output logic                   PROBE_OUT_B_O,
  output logic                   PROBE_OUT_C_O,
  output logic                   PROBE_OUT_D_O
);
  localparam int BSR_W = `CELLS_PER_IO * NUM_IO;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (NUM_IO < 1) begin : g_no_io
    $error("NUM_IO must be at least one");
  end
  if (`USERSIG_W > `USERCODE_W) begin : g_sig_wide
    $error("user signature wider than user register");
  end
  if (`IDCODE_W > `USERCODE_W) begin : g_id_wide
    $error("identification wider than shared shift register");
  end

  // ****************************************
  // tck domain state
  // ****************************************
  typedef struct packed {
    scan_regs_pkg::tap_e     tap;
    logic [`IR_W-1:0]        ir_sh;
    logic [`IR_W-1:0]        ir;
    logic [2:0]              errn;
    logic [`USERCODE_W-1:0]  dr_sh;
    logic [BSR_W-1:0]        bsr_sh;
    logic [BSR_W-1:0]        bsr_hold;
    logic                    byp;
    logic                    tgl;
  } tck_s;

  tck_s t_reg;
  tck_s t_next;
  // error levels arrive from another clock, so they pass two flops
  logic [2:0] err_a_reg;
  logic [2:0] err_b_reg;

  // decoded tap states, shared by tdo, errors and probes
  logic in_tlr;
  logic in_shd;
  logic in_shi;
  logic in_uir;

  scan_regs_pkg::sel_e sel;
  logic [`USERCODE_W-1:0] user_val;
  logic [BSR_W-1:0] bsr_cap;
  logic [NUM_IO-1:0] ext_mode;

  // fuse bits beyond the signature field never reach the chain
  localparam logic [`USERCODE_W-1:0] SIG_MASK = {{(`USERCODE_W-`USERSIG_W){1'b0}}, {`USERSIG_W{1'b1}}};
  assign user_val = USER_FUSE & SIG_MASK;

  // ****************************************
  // state decode
  // ****************************************
  assign in_tlr = (t_reg.tap == scan_regs_pkg::TLR);
  assign in_shd = (t_reg.tap == scan_regs_pkg::SHD);
  assign in_shi = (t_reg.tap == scan_regs_pkg::SHI);
  assign in_uir = (t_reg.tap == scan_regs_pkg::UIR);

  // ****************************************
  // instruction decode
  // ****************************************
  // anything not listed falls to bypass, so unused codes stay harmless

  always_comb begin
    unique case (t_reg.ir)
      `INS_IDCODE:                sel = scan_regs_pkg::SEL_ID;
      `INS_USERCODE:              sel = scan_regs_pkg::SEL_USR;
      `INS_EXTEST, `INS_SAMPLE:   sel = scan_regs_pkg::SEL_BSR;
      default:                    sel = scan_regs_pkg::SEL_BYP;
    endcase
  end

  // ****************************************
  // boundary capture
  // ****************************************
  // capture order per io: enable (high), output, input (low) toward tdo
  always_comb begin
    bsr_cap = '0;
    for (int i = 0; i < NUM_IO; i++) begin
      bsr_cap[`CELLS_PER_IO*i+`CELL_OE]  = CORE_OE_I[i];
      bsr_cap[`CELLS_PER_IO*i+`CELL_OUT] = CORE_OUT_I[i];
      bsr_cap[`CELLS_PER_IO*i+`CELL_IN]  = PIN_IN_I[i];
    end
  end

  // ****************************************
  // tap and scan next state
  // ****************************************
  always_comb begin
    t_next = t_reg;
    unique case (t_reg.tap)
      scan_regs_pkg::TLR: t_next.tap = TMS_I ? scan_regs_pkg::TLR : scan_regs_pkg::RTI;
      scan_regs_pkg::RTI: t_next.tap = TMS_I ? scan_regs_pkg::SDS : scan_regs_pkg::RTI;
      scan_regs_pkg::SDS: t_next.tap = TMS_I ? scan_regs_pkg::SIS : scan_regs_pkg::CDR;
      scan_regs_pkg::CDR: t_next.tap = TMS_I ? scan_regs_pkg::E1D : scan_regs_pkg::SHD;
      scan_regs_pkg::SHD: t_next.tap = TMS_I ? scan_regs_pkg::E1D : scan_regs_pkg::SHD;
      scan_regs_pkg::E1D: t_next.tap = TMS_I ? scan_regs_pkg::UDR : scan_regs_pkg::PDR;
      scan_regs_pkg::PDR: t_next.tap = TMS_I ? scan_regs_pkg::E2D : scan_regs_pkg::PDR;
      scan_regs_pkg::E2D: t_next.tap = TMS_I ? scan_regs_pkg::UDR : scan_regs_pkg::SHD;
      scan_regs_pkg::UDR: t_next.tap = TMS_I ? scan_regs_pkg::SDS : scan_regs_pkg::RTI;
      scan_regs_pkg::SIS: t_next.tap = TMS_I ? scan_regs_pkg::TLR : scan_regs_pkg::CIR;
      scan_regs_pkg::CIR: t_next.tap = TMS_I ? scan_regs_pkg::E1I : scan_regs_pkg::SHI;
      scan_regs_pkg::SHI: t_next.tap = TMS_I ? scan_regs_pkg::E1I : scan_regs_pkg::SHI;
      scan_regs_pkg::E1I: t_next.tap = TMS_I ? scan_regs_pkg::UIR : scan_regs_pkg::PIR;
      scan_regs_pkg::PIR: t_next.tap = TMS_I ? scan_regs_pkg::E2I : scan_regs_pkg::PIR;
      scan_regs_pkg::E2I: t_next.tap = TMS_I ? scan_regs_pkg::UIR : scan_regs_pkg::SHI;
      scan_regs_pkg::UIR: t_next.tap = TMS_I ? scan_regs_pkg::SDS : scan_regs_pkg::RTI;
    endcase
    // errors are sticky until update-ir or test reset; a new error wins
    if (in_uir || in_tlr) begin
      t_next.errn = `ERRN_IDLE;
    end
    t_next.errn = t_next.errn & err_b_reg;
    unique case (t_reg.tap)
      scan_regs_pkg::TLR: begin
        t_next.ir = `INS_IDCODE;
      end
      scan_regs_pkg::CIR: begin
        t_next.ir_sh = `IR_CAPTURE & ~(`IR_ERR_MASK & ~{t_reg.errn, 2'b00});
      end
      scan_regs_pkg::SHI: begin
        t_next.ir_sh = {TDI_I, t_reg.ir_sh[`IR_W-1:1]};
      end
      scan_regs_pkg::UIR: begin
        t_next.ir = t_reg.ir_sh;
      end
      scan_regs_pkg::CDR: begin
        // bypass always captures zero
        t_next.byp = 1'b0;
        unique case (sel)
          scan_regs_pkg::SEL_ID:  t_next.dr_sh = {{(`USERCODE_W-`IDCODE_W){1'b0}}, ID_VALUE};
          scan_regs_pkg::SEL_USR: t_next.dr_sh = user_val;
          scan_regs_pkg::SEL_BSR: t_next.bsr_sh = bsr_cap;
          default: ;
        endcase
      end
      scan_regs_pkg::SHD: begin
        unique case (sel)
          scan_regs_pkg::SEL_ID: begin
            t_next.dr_sh[`IDCODE_W-1:0] = {TDI_I, t_reg.dr_sh[`IDCODE_W-1:1]};
          end
          scan_regs_pkg::SEL_USR: t_next.dr_sh = {TDI_I, t_reg.dr_sh[`USERCODE_W-1:1]};
          scan_regs_pkg::SEL_BSR: t_next.bsr_sh = {TDI_I, t_reg.bsr_sh[BSR_W-1:1]};
          default:                t_next.byp = TDI_I;
        endcase
      end
      scan_regs_pkg::UDR: begin
        // hold latches keep pins steady while a new pattern shifts in
        if (sel == scan_regs_pkg::SEL_BSR) begin
          t_next.bsr_hold = t_reg.bsr_sh;
        end
      end
      default: ;
    endcase
    if (t_next.tap != t_reg.tap) begin
      t_next.tgl = ~t_reg.tgl;
    end
  end

  // ****************************************
  // tck domain registers
  // ****************************************
  always_ff @(posedge TCK_I) begin
    err_a_reg  <= ERRN_I;
    err_b_reg  <= err_a_reg;
    if (!TRSTN_I) begin
      t_reg      <= '0;
      t_reg.tap  <= scan_regs_pkg::TLR;
      t_reg.ir   <= `INS_IDCODE;
      t_reg.errn <= `ERRN_IDLE;
    end else begin
      t_reg <= t_next;
    end
  end

  // ****************************************
  // tdo on falling tck
  // ****************************************
  logic tdo_bit;
  always_comb begin
    unique case (sel)
      scan_regs_pkg::SEL_ID, scan_regs_pkg::SEL_USR: tdo_bit = t_reg.dr_sh[0];
      scan_regs_pkg::SEL_BSR:                        tdo_bit = t_reg.bsr_sh[0];
      default:                                       tdo_bit = t_reg.byp;
    endcase
    // instruction shift overrides whichever data path is selected
    if (in_shi) begin
      tdo_bit = t_reg.ir_sh[0];
    end
  end

  always_ff @(negedge TCK_I) begin
    if (!TRSTN_I) begin
      TDO_O     <= 1'b1;
      TDO_OEN_O <= 1'b1;
    end else begin
      TDO_O     <= tdo_bit;
      TDO_OEN_O <= !(in_shd || in_shi);
    end
  end

  // ****************************************
  // boundary muxes
  // ****************************************
  // extest drives pins from hold latches
  always_comb begin
    for (int i = 0; i < NUM_IO; i++) begin
      ext_mode[i] = (t_reg.ir == `INS_EXTEST);
    end
  end
  always_ff @(posedge TCK_I) begin
    for (int i = 0; i < NUM_IO; i++) begin
      PIN_OE_O[i]  <= ext_mode[i] ? t_reg.bsr_hold[`CELLS_PER_IO*i+`CELL_OE]  : CORE_OE_I[i];
      PIN_OUT_O[i] <= ext_mode[i] ? t_reg.bsr_hold[`CELLS_PER_IO*i+`CELL_OUT] : CORE_OUT_I[i];
      CORE_IN_O[i] <= ext_mode[i] ? t_reg.bsr_hold[`CELLS_PER_IO*i+`CELL_IN]  : PIN_IN_I[i];
    end
  end

  // ****************************************
  // probes in system clock domain
  // ****************************************
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] probe_out_b;
  } sys_s;
  sys_s s_reg;
  sys_s s_next;

  // each probe bit is synchronised on its own; states last a full tck
  // period, longer than three system clocks, so skew between bits is harmless
  always_comb begin
    s_next     = s_reg;
    s_next.s1  = {t_reg.tgl, in_shd, in_shi, in_tlr};
    s_next.s2  = s_reg.s1;
    s_next.probe_out_b = s_reg.s2;
  end
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign PROBE_OUT_A_O = s_reg.probe_out_b[0];
  assign PROBE_OUT_B_O = s_reg.probe_out_b[1];
  assign PROBE_OUT_C_O = s_reg.probe_out_b[2];
  assign PROBE_OUT_D_O = s_reg.probe_out_b[3];
endmodule : jtag_scan_data_registers
`default_nettype wire

// File: rtl/scan_regs_cfg.svh
`ifndef SCAN_REGS_CFG_SVH
`define SCAN_REGS_CFG_SVH
`define IR_W          5
`define IDCODE_W      20
`define USERCODE_W    33
`define USERSIG_W     20
`define IR_CAPTURE    5'h1D
`define IR_ERR_MASK   5'h1C
`define INS_EXTEST    5'h00
`define INS_SAMPLE    5'h01
`define INS_IDCODE    5'h0F
`define INS_USERCODE  5'h0E
`define INS_BYPASS    5'h1F
`define ERRN_IDLE     3'h7
`define CELLS_PER_IO  3
`define CELL_OE       2
`define CELL_OUT      1
`define CELL_IN       0
`endif

// File: rtl/scan_regs_pkg.sv
package scan_regs_pkg;
  // gray-coded tap states
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SDS = 4'h3, CDR = 4'h2,
    SHD = 4'h6, E1D = 4'h7, PDR = 4'h5, E2D = 4'h4,
    UDR = 4'hC, SIS = 4'hD, CIR = 4'hF, SHI = 4'hE,
    E1I = 4'hA, PIR = 4'hB, E2I = 4'h9, UIR = 4'h8
  } tap_e;
  typedef enum logic [1:0] {SEL_BYP = 2'h0, SEL_ID = 2'h1, SEL_USR = 2'h2, SEL_BSR = 2'h3} sel_e;
endpackage : scan_regs_pkg

// File: verification/jtag_scan_data_registers_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ***
// port checks
// ***
module jtag_scan_data_registers_checker (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic TCK_I,
  input wire logic TDO_O,
  input wire logic TDO_OEN_O,
  input wire logic PROBE_OUT_A_O,
  input wire logic PROBE_OUT_B_O,
  input wire logic PROBE_OUT_C_O,
  input wire logic PROBE_OUT_D_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_shift_entry;
    $rose(PROBE_OUT_B_O) || $rose(PROBE_OUT_C_O);
  endsequence
  a_probe_onehot: assert property ($onehot0({PROBE_OUT_A_O, PROBE_OUT_B_O, PROBE_OUT_C_O}))
    else $error("probe states overlap");
  a_entry_toggle: assert property (s_shift_entry |-> $changed(PROBE_OUT_D_O))
    else $error("state change probe did not toggle");
  // tck period is over three system clocks, so toggles cannot come closer
  a_toggle_spacing: assert property ($changed(PROBE_OUT_D_O) |=> $stable(PROBE_OUT_D_O) [*2])
    else $error("state change probe toggles too fast");
  a_entry_drives: assert property (s_shift_entry |-> !TDO_OEN_O)
    else $error("tdo not driven in shift");
  a_reset_release: assert property ($rose(PROBE_OUT_A_O) |-> TDO_OEN_O)
    else $error("tdo driven in test reset");
  a_drive_in_shift: assert property (!TDO_OEN_O [*4] |-> PROBE_OUT_B_O || PROBE_OUT_C_O)
    else $error("tdo driven outside shift");
  a_tdo_on_fall: assert property ($changed(TDO_O) && !TDO_OEN_O |-> !TCK_I)
    else $error("tdo moved while tck high");
  a_enable_on_fall: assert property ($fell(TDO_OEN_O) |-> !TCK_I)
    else $error("tdo enable moved while tck high");
endmodule : jtag_scan_data_registers_checker
`default_nettype wire

// File: verification/jtag_tester_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***
// external scan tester
// ***
module jtag_tester_model (
  // test port
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  output var logic trstn_o,
  input  wire logic tdo_i
);
  initial begin
    {tck_o, tms_o, tdi_o, trstn_o} = 4'h4;
  end
  // tck stands still between calls; tdo is taken at the rising edge, half a period after it settled
  task automatic cycle(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #40 tck_o = 1'b1;
    tdo = tdo_i;
    #80 tck_o = 1'b0;
    #40;
  endtask : cycle
  // ends in test-logic-reset
  task automatic reset_tap();
    logic d;
    trstn_o = 1'b0;
    repeat (5) cycle(1'b1, 1'b0, d);
    trstn_o = 1'b1;
  endtask : reset_tap
endmodule : jtag_tester_model
`default_nettype wire

// File: verification/test_jtag_scan_data_registers.sv
`timescale 1ns/100ps
`default_nettype none
`include "scan_regs_cfg.svh"
// ***
// bench top
// ***
module test_jtag_scan_data_registers;
  localparam logic [19:0] ID    = 20'h0_5A3C; // arbitrary value
  localparam logic [32:0] UFUSE = 33'h0_000C_3A96;
  logic       clk_i    = 1'b0;
  logic       resetn_i = 1'b0;
  logic [2:0] errn_i   = 3'h7;
  logic [3:0] pin_in   = 4'h5;
  logic [3:0] core_out = 4'h6;
  logic [3:0] core_oe  = 4'hC;
  logic       tck, tms, tdi, trstn, tdo, tdo_oen, pa;
  logic [3:0] pin_out, pin_oe, core_in;
  int         fail_count   = 0;
  int         total_checks = 0;
  always #25 clk_i = ~clk_i;
  jtag_tester_model tester_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trstn_o(trstn), .tdo_i(tdo));
  jtag_scan_data_registers #(.NUM_IO(4), .ID_VALUE(ID), .USER_FUSE(UFUSE)) dut_u (
    .CLK_I(clk_i), .RESETN_I(resetn_i), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TRSTN_I(trstn),
    .TDO_O(tdo), .TDO_OEN_O(tdo_oen), .ERRN_I(errn_i), .PIN_IN_I(pin_in), .CORE_OUT_I(core_out),
    .CORE_OE_I(core_oe), .PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe), .CORE_IN_O(core_in),
    .PROBE_OUT_A_O(pa), .PROBE_OUT_B_O(), .PROBE_OUT_C_O(), .PROBE_OUT_D_O());
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic go(input logic tms_v);
    logic d;
    tester_u.cycle(tms_v, 1'b0, d);
  endtask : go
  // idle to shift, n bits lsb first, then update and back to idle
  task automatic scan(input logic ir_v, input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    go(1'b1);
    if (ir_v) go(1'b1);
    go(1'b0);
    go(1'b0);
    for (int i = 0; i < n; i++) tester_u.cycle(i == n - 1, din[i], dout[i]);
    go(1'b1);
    go(1'b0);
  endtask : scan
  task automatic ir(input logic [4:0] ins, input logic [4:0] exp);
    logic [63:0] q;
    scan(1'b1, 5, 64'(ins), q);
    chk("ir capture", 64'(exp), q);
  endtask : ir
  task automatic t_reset_id();
    logic [63:0] q;
    repeat (4) @(posedge clk_i);
    chk("tdo enable", 64'h1, 64'(tdo_oen));
    chk("reset probe", 64'h1, 64'(pa));
    go(1'b0);
    // length 20 shows as the pattern reappearing after the captured code
    scan(1'b0, 40, 64'h6_9F1C, q);
    chk("idcode", {24'h0, 20'h6_9F1C, ID}, q);
    $display("reset and idcode done");
  endtask : t_reset_id
  task automatic t_errors();
    @(posedge clk_i) errn_i <= 3'h0;
    repeat (4) @(posedge clk_i);
    ir(`INS_BYPASS, `IR_CAPTURE & ~`IR_ERR_MASK);
    @(posedge clk_i) errn_i <= 3'h7;
    repeat (4) @(posedge clk_i);
    ir(`INS_BYPASS, `IR_CAPTURE & ~`IR_ERR_MASK);
    ir(`INS_BYPASS, `IR_CAPTURE);
    $display("error capture done");
  endtask : t_errors
  task automatic t_user();
    logic [63:0] q;
    ir(`INS_USERCODE, `IR_CAPTURE);
    scan(1'b0, 64, 64'h1357_9BDF, q);
    chk("usercode", {31'h1357_9BDF, UFUSE}, q);
    $display("usercode done");
  endtask : t_user
  task automatic t_bypass();
    logic [4:0]  ins [3] = '{`INS_BYPASS, 5'h15, 5'h02};
    logic [63:0] q;
    foreach (ins[i]) begin
      ir(ins[i], `IR_CAPTURE);
      scan(1'b0, 8, 64'hB5, q);
      chk("bypass", 64'h35, 64'(q[7:1]));
    end
    $display("bypass done");
  endtask : t_bypass
  task automatic t_bsr();
    logic [63:0] q, e;
    e = {40'h0, 12'hA6C, 12'h0};
    for (int i = 0; i < 4; i++) e[3*i +: 3] = {core_oe[i], core_out[i], pin_in[i]};
    ir(`INS_SAMPLE, `IR_CAPTURE);
    scan(1'b0, 24, 64'hA6C, q);
    chk("bsr capture", e, q);
    chk("core in sample", 64'(pin_in), 64'(core_in));
    ir(`INS_EXTEST, `IR_CAPTURE);
    scan(1'b0, 12, 64'h6B5, q);
    go(1'b0);
    go(1'b0);
    chk("pin enable", 64'h3, 64'(pin_oe));
    chk("pin out", 64'hE, 64'(pin_out));
    chk("core in extest", 64'h9, 64'(core_in));
    $display("boundary done");
  endtask : t_bsr
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    // test reset runs alongside system reset so no state is unknown at release
    fork
      tester_u.reset_tap();
      begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
      end
    join
    #7;
    t_reset_id();
    t_errors();
    t_user();
    t_bypass();
    t_bsr();
    tally_and_finish();
  end
endmodule : test_jtag_scan_data_registers
bind jtag_scan_data_registers jtag_scan_data_registers_checker chk_u (.CLK_I, .RESETN_I, .TCK_I, .TDO_O,
  .TDO_OEN_O, .PROBE_OUT_A_O, .PROBE_OUT_B_O, .PROBE_OUT_C_O, .PROBE_OUT_D_O);
`default_nettype wire
